/* qots_map.svh */
// Summary of operation
// RULE1: a stored load program moves the sequencer from standby into counting.
// RULE2: the count clock is the 4 Hz time base divided down to one count per four seconds.
// RULE3: the quarter-orbit counter is preset at load with program bits 5 to 14.
// RULE4: the first count lands 4 to 4.3 s after the last program bit.
// RULE5: the counter overflows after the two's complement of the delay, marking the epoch (1 to 1024 counts).
// RULE6: at the epoch the counter clears and times the quarter orbit.
// RULE7: with bit 4 clear the normal program raises the first-quarter output at the epoch.
// RULE8: at count 256 of each quarter bits 22 to 28 load the low seven counter stages.
// RULE9: a quarter ends on overflow of the low nine stages, giving 385 to 512 counts.
// RULE10: at the first quarter end the first-quarter output falls and the second-quarter output rises.
// RULE11: at the next nine-stage overflow the tenth stage overflows and the second-quarter output falls.
// RULE12: a three-stage cycle counter preset from bits 1 to 3 ends the run in standby on overflow.
// RULE13: in proportional mode stages 3 to 9 are compared with bits 15 to 21 after the reload to raise the first-quarter output.
// RULE14: in proportional mode the first-quarter output falls at quarter end and the second quarter stays quiet.
// RULE15: in proportional mode the cycle counter holds, and bits 1 to 4 all ones means standby.
// RULE16: software keeps the on-time in 16 s steps within the quarter orbit minus 1024 s.
// RULE17: a new load aborts any sequence, clears both outputs and restarts.
`ifndef QOTS_MAP_SVH
`define QOTS_MAP_SVH
`define QOTS_PROG_OFFS 12'h000
`define QOTS_STAT_OFFS 12'h004
`define QOTS_PROG_RST 28'h0000000
`define QOTS_CYC_LSB 0
`define QOTS_PROP_BIT 3
`define QOTS_DELAY_LSB 4
`define QOTS_ONTIME_LSB 14
`define QOTS_CORR_LSB 21
`define QOTS_TICKS_PER_COUNT 5'd16
`define QOTS_FIRST_TICKS 5'd17
`define QOTS_MID_COUNT 9'h100
`define QOTS_STAT_CYC_LSB 4
`define QOTS_STAT_CNT_LSB 16
`endif

/* qots_pkg.sv */
package qots_pkg;
  typedef enum logic [1:0] {
    QOTS_STANDBY = 2'b00,
    QOTS_DELAY = 2'b01,
    QOTS_RUN = 2'b10
  } qots_state_t;
endpackage : qots_pkg

/* qots_sequencer.sv */
`timescale 1ns/100ps
`include "qots_map.svh"
module qots_sequencer import qots_pkg::*; (
  input wire logic clk, // 100 MHz
  input wire logic rst_n, // async, active low
  input wire logic timeBaseTick, // one-cycle 4 Hz time base strobe
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic firstQuarter, // first-quarter torquing level
  output logic secondQuarter // second-quarter torquing level
);
  logic [27:0] prog;
  qots_state_t state;
  qots_state_t next_state;
  logic [9:0] qCnt;
  logic [9:0] next_qCnt;
  logic [2:0] cyc;
  logic [2:0] next_cyc;
  logic [4:0] preCnt;
  logic reloaded;
  logic next_reloaded;
  logic next_first;
  logic next_second;

  wire apbAccess = psel & penable & ~pready;
  wire hitProg = (paddr == `QOTS_PROG_OFFS);
  wire hitStat = (paddr == `QOTS_STAT_OFFS);
  wire loadWr = apbAccess & pwrite & hitProg;
  wire [27:0] newProg = pwdata[27:0];

  wire prop = prog[`QOTS_PROP_BIT];
  wire [9:0] delayField = prog[`QOTS_DELAY_LSB +: 10];
  wire [6:0] onTime = prog[`QOTS_ONTIME_LSB +: 7];
  wire [6:0] corr = prog[`QOTS_CORR_LSB +: 7];
  wire [2:0] cycField = prog[`QOTS_CYC_LSB +: 3];
  wire newIdle = (newProg[3:0] == 4'hf);

  wire cntEn = timeBaseTick & (preCnt == 5'd1);
  wire [9:0] incCnt = qCnt + 10'h001;
  wire nineOvf = (qCnt[8:0] == 9'h1ff);
  wire atMid = (incCnt[8:0] == `QOTS_MID_COUNT);
  wire propHit = prop & reloaded & ~qCnt[9] & (qCnt[8:2] == onTime);

  wire [31:0] statWord = {6'h00, qCnt, 9'h000, cyc,
                          secondQuarter, firstQuarter, state};
  wire [31:0] rdMux = hitProg ? {4'h0, prog} :
                      hitStat ? statWord : 32'h00000000;

  // apb: one wait state, data and ready both registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apbAccess;
      pslverr <= apbAccess & ~hitProg & ~hitStat;
      if (apbAccess && !pwrite) begin
        prdata <= rdMux;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog <= `QOTS_PROG_RST;
    end else if (loadWr) begin
      prog <= newProg;
    end
  end

  // tick prescaler restarts at load so the first count waits one extra
  // tick: 4 s worth of ticks plus up to one 0.25 s tick of phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt <= `QOTS_FIRST_TICKS;
    end else if (loadWr) begin
      preCnt <= `QOTS_FIRST_TICKS; // see RULE4
    end else if (timeBaseTick) begin
      preCnt <= cntEn ? `QOTS_TICKS_PER_COUNT
                      : preCnt - 5'd1; // see RULE2
    end
  end

  always_comb begin
    next_state = state;
    next_qCnt = qCnt;
    next_cyc = cyc;
    next_reloaded = reloaded;
    next_first = firstQuarter;
    next_second = secondQuarter;
    if (loadWr) begin
      next_first = 1'b0; // see RULE17
      next_second = 1'b0;
      next_reloaded = 1'b0;
      next_qCnt = newProg[`QOTS_DELAY_LSB +: 10]; // see RULE3
      next_cyc = newProg[`QOTS_CYC_LSB +: 3];
      if (newIdle) begin
        next_state = QOTS_STANDBY; // see RULE15
      end else begin
        next_state = QOTS_DELAY; // see RULE1
      end
    end else begin
      case (state)
        QOTS_DELAY: begin
          if (cntEn) begin
            next_qCnt = incCnt;
            if (qCnt == 10'h3ff) begin
              next_qCnt = 10'h000; // see RULE5
              next_state = QOTS_RUN; // see RULE6
              next_first = ~prop; // see RULE7
            end
          end
        end
        QOTS_RUN: begin
          if (propHit) begin
            next_first = 1'b1; // see RULE13
          end
          if (cntEn) begin
            next_qCnt = incCnt;
            if (atMid) begin
              next_qCnt = {incCnt[9:7], corr}; // see RULE8
              next_reloaded = 1'b1;
            end
            if (nineOvf) begin
              next_reloaded = 1'b0; // see RULE9
              if (!qCnt[9]) begin
                next_first = 1'b0; // see RULE10
                next_second = ~prop; // see RULE14
              end else begin
                next_second = 1'b0; // see RULE11
                if (!prop) begin
                  next_cyc = cyc + 3'd1; // see RULE12
                  if (cyc == 3'h7) begin
                    next_state = QOTS_STANDBY;
                  end
                end
              end
            end
          end
        end
        default: begin
          next_first = 1'b0;
          next_second = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= QOTS_STANDBY;
      qCnt <= 10'h000;
      cyc <= 3'h0;
      reloaded <= 1'b0;
      firstQuarter <= 1'b0;
      secondQuarter <= 1'b0;
    end else begin
      state <= next_state;
      qCnt <= next_qCnt;
      cyc <= next_cyc;
      reloaded <= next_reloaded;
      firstQuarter <= next_first;
      secondQuarter <= next_second;
    end
  end
endmodule : qots_sequencer

/* qots_sequencer_sva.sv */
`timescale 1ns/100ps
module qots_chk (
  input logic clk,
  input logic rst_n,
  input logic timeBaseTick,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic firstQuarter,
  input logic secondQuarter
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_acc; psel && penable && pready; endsequence
  property p_wait; psel && penable && !pready |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_map;
    s_acc |-> pslverr == (paddr != 12'h000 && paddr != 12'h004);
  endproperty
  property p_top;
    s_acc ##0 (!pwrite && paddr == 12'h000) |-> prdata[31:28] == 4'h0;
  endproperty
  property p_excl; !(firstQuarter && secondQuarter); endproperty
  property p_swap; $rose(secondQuarter) |-> $fell(firstQuarter); endproperty
  property p_drop;
    $fell(secondQuarter) |-> $past(timeBaseTick) || pready;
  endproperty
  // first-quarter level only ends on a counted tick or on a new load
  property p_hold;
    $fell(firstQuarter) |-> $past(timeBaseTick) || pready;
  endproperty
  a_wait: assert property (p_wait) else $error("no ready");
  a_one: assert property (p_one) else $error("long ready");
  a_err: assert property (p_err) else $error("lone error");
  a_map: assert property (p_map) else $error("bad error");
  a_top: assert property (p_top) else $error("top bits");
  a_excl: assert property (p_excl) else $error("both on");
  a_swap: assert property (p_swap) else $error("no swap");
  a_drop: assert property (p_drop) else $error("odd drop");
  a_hold: assert property (p_hold) else $error("short on");
endmodule : qots_chk
bind qots_sequencer qots_chk chk (.*);

/* qots_tick_src.sv */
`timescale 1ns/100ps
module qots_tick_src (
  input logic clk, // bench clock
  input logic rst_n, // async reset
  input logic run, // tick source enabled
  output logic tick // one-cycle time-base strobe
);
  // sped-up time base so whole quarters fit in the run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      tick <= 1'b0;
    else
      tick <= run && !tick;
  end
endmodule : qots_tick_src

/* test_quarter_orbit_torque_sequencer.sv */
`timescale 1ns/100ps
module test_quarter_orbit_torque_sequencer;
  logic clk = 0, rst_n = 0, run = 0, tick, pready, pslverr, fq, sq;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, v, eq[$], mq[$];
  logic errq[$];
  int bad_count = 0, check_count = 0, seed = 87664, n, k;
  always #5 clk = ~clk;
  qots_tick_src src (.clk(clk), .rst_n(rst_n), .run(run), .tick(tick));
  qots_sequencer uut (.clk(clk), .rst_n(rst_n), .timeBaseTick(tick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .firstQuarter(fq), .secondQuarter(sq));
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  task chk(input logic ok, input string s);
    check_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask : chk
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      chk((prdata & mq[0]) === eq[0] && pslverr === errq[0], "apb");
      void'(eq.pop_front());
      void'(mq.pop_front());
      void'(errq.pop_front());
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic [31:0] m, input logic er);
    eq.push_back(e & m);
    mq.push_back(m);
    errq.push_back(er);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(0, "apb hang");
      stop_test();
    end
    psel <= 0;
    penable <= 0;
    // idle edge so the next setup never reassigns psel in this step
    @(posedge clk);
  endtask : apb
  task waitfor(input logic s, input logic val, input int lim);
    k = 0;
    while ((s ? sq : fq) !== val && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (k >= lim) begin
      chk(0, "hang");
      stop_test();
    end
  endtask : waitfor
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    run <= 1;
    @(posedge clk);
    chk(fq === 0 && sq === 0, "reset");
    v = {4'h0, 7'h7f, 7'h00, 10'h3ff, 4'h7};
    apb(1, 12'h000, v, 0, 0, 0);
    waitfor(0, 1, 2000);
    waitfor(1, 1, 20000);
    chk(k === 12320, "first quarter");
    waitfor(1, 0, 20000);
    chk(k === 12320, "second quarter");
    apb(0, 12'h004, 0, 0, 32'hf, 0);
    $display("normal test done");
    apb(1, 12'h000, v, 0, 0, 0);
    waitfor(0, 1, 2000);
    apb(1, 12'h000, v, 0, 0, 0);
    chk(fq === 0 && sq === 0, "abort");
    $display("abort test done");
    v = $random(seed);
    v[3:0] = 4'hf;
    apb(1, 12'h000, v, 0, 0, 0);
    apb(0, 12'h000, 0, v, 32'h0fffffff, 0);
    apb(0, 12'h004, 0, 0, 32'hf, 0);
    apb(0, 12'h008, 0, 0, 32'hffffffff, 1);
    // on-time 0x7c: stages 3 to 9 match at counts 496 to 499, raising first-quarter until quarter end
    v = {4'h0, 7'h7f, 7'h7c, 10'h3ff, 4'h8};
    apb(1, 12'h000, v, 0, 0, 0);
    waitfor(0, 1, 20000);
    chk(sq === 0, "prop second");
    waitfor(0, 0, 2000);
    chk(k === 511, "prop on time");
    $display("proportional test done");
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule : test_quarter_orbit_torque_sequencer
